/* verilog/stc_pkg.sv */
// Purpose: constants and types for the odd timer control block
// Assumes: 32-bit apb data, registers on aligned words
// Notes: Behaviour list below
// Behaviour
// - with the internal clock chosen, the gate enable bit turns gated accumulation on or off.
// - with the external clock chosen, the gate enable bit has no effect.
// - the prescale field at bits 5:4 divides by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
// - clock source bit 1 counts external pin rising edges, bit 0 counts the internal half-rate clock.
// - in 32-bit pair mode this timer's own control bits are ignored and the partner's are used.
package stc_pkg;

	localparam logic [11:0] STC_CTRL_OFS   = 12'h000;
	localparam logic [11:0] STC_COUNT_OFS  = 12'h004;
	localparam logic [11:0] STC_PERIOD_OFS = 12'h008;
	localparam logic [11:0] STC_STATUS_OFS = 12'h00C;

	localparam int STC_ON_BIT    = 15;
	localparam int STC_GATE_BIT  = 6;
	localparam int STC_PS_LSB    = 4;
	localparam int STC_CS_BIT    = 1;

	localparam logic [15:0] STC_CTRL_RST   = 16'h0000;
	localparam logic [15:0] STC_CTRL_MASK  = 16'h8072;
	localparam logic [15:0] STC_COUNT_RST  = 16'h0000;
	localparam logic [15:0] STC_PERIOD_RST = 16'hFFFF;

	localparam logic [7:0] STC_DIV256_M1 = 8'hFF;
	localparam logic [7:0] STC_DIV64_M1  = 8'h3F;
	localparam logic [7:0] STC_DIV8_M1   = 8'h07;
	localparam logic [7:0] STC_DIV1_M1   = 8'h00;

	typedef struct packed {
		logic       on;
		logic       gate_accum_enable;
		logic [1:0] input_prescale_select;
		logic       clock_source_select;
	} stc_ctrl_s;

	typedef struct packed {
		logic [11:0] addr;
		logic        write;
		logic [31:0] wdata;
	} stc_req_s;

endpackage

/* verilog/stc_pin_sync.sv */
// Purpose: three-stage synchroniser with edge output
// Assumes: input asynchronous to pclk
// Notes: level changes once the second and third stage agree
`timescale 1ns/1ps
module stc_pin_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin_in,
	output logic      level,
	output logic      rise
);
	logic [2:0] sh_reg;
	logic [2:0] sh_next;
	logic       lvl_reg;
	logic       lvl_next;

	always_comb begin
		sh_next  = {sh_reg[1:0], pin_in};
		lvl_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : lvl_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_reg  <= 3'b000;
			lvl_reg <= 1'b0;
		end else begin
			sh_reg  <= sh_next;
			lvl_reg <= lvl_next;
		end
	end

	assign level = lvl_reg;
	assign rise  = lvl_next & ~lvl_reg;
endmodule

/* verilog/stc_prescaler.sv */
// Purpose: input prescaler 1, 8, 64 or 256
// Assumes: tick_in is a one-cycle pulse
// Notes: counter restarts when clear is high
`timescale 1ns/1ps
module stc_prescaler
	import stc_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       clear,
	input  wire logic [1:0] sel,
	input  wire logic       tick_in,
	output logic            tick_out
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [7:0] limit;

	always_comb begin
		unique case (sel)
			2'b11: limit = STC_DIV256_M1;
			2'b10: limit = STC_DIV64_M1;
			2'b01: limit = STC_DIV8_M1;
			2'b00: limit = STC_DIV1_M1;
		endcase
		tick_out = tick_in && (cnt_reg >= limit);
		cnt_next = cnt_reg;
		if (clear) begin
			cnt_next = 8'h00;
		end else if (tick_in) begin
			cnt_next = tick_out ? 8'h00 : cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule

/* verilog/stc_top.sv */
// Purpose: odd timer of a pair with apb control register
// Assumes: pclk is the oscillator clock; internal tick is every 2nd cycle
// Notes: zero wait state apb slave; unmapped addresses give pslverr
`timescale 1ns/1ps
module stc_top
	import stc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        external_count_pin,
	input  wire logic        gate_pin,
	input  wire logic        pair_32bit,
	input  wire logic [15:0] partner_ctrl,
	output logic [15:0]      count_value,
	output logic             period_match
);
	logic [15:0] ctrl_reg;
	logic [15:0] ctrl_next;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [15:0] period_reg;
	logic [15:0] period_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic        match_reg;
	logic        match_next;
	logic        half_reg;
	logic        half_next;
	logic        gate_dly_reg;
	logic        gate_dly_next;
	logic        ovf_reg;
	logic        ovf_next;

	stc_req_s    req;
	stc_ctrl_s   eff;
	logic        acc;
	logic        wr;
	logic        hit;
	logic        ext_level;
	logic        ext_rise;
	logic        gate_level;
	logic        raw_tick;
	logic        ps_tick;
	logic        ps_clear;
	logic        gated_mode;
	logic        adv;

	assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
	assign acc = psel && penable;
	assign wr  = acc && req.write;
	assign hit = (req.addr == STC_CTRL_OFS) || (req.addr == STC_COUNT_OFS)
		|| (req.addr == STC_PERIOD_OFS) || (req.addr == STC_STATUS_OFS);

	stc_pin_sync u_ext_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (external_count_pin),
		.level   (ext_level),
		.rise    (ext_rise)
	);

	stc_pin_sync u_gate_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (gate_pin),
		.level   (gate_level),
		.rise    ()
	);

	// paired mode takes every field from the partner control word
	always_comb begin
		if (pair_32bit) begin
			eff.on                    = partner_ctrl[STC_ON_BIT];
			eff.gate_accum_enable     = partner_ctrl[STC_GATE_BIT];
			eff.input_prescale_select =
				partner_ctrl[STC_PS_LSB+1:STC_PS_LSB];
			eff.clock_source_select   = partner_ctrl[STC_CS_BIT];
		end else begin
			eff.on                    = ctrl_reg[STC_ON_BIT];
			eff.gate_accum_enable     = ctrl_reg[STC_GATE_BIT];
			eff.input_prescale_select =
				ctrl_reg[STC_PS_LSB+1:STC_PS_LSB];
			eff.clock_source_select   = ctrl_reg[STC_CS_BIT];
		end
	end

	// gate only counts with the internal source
	assign gated_mode = eff.gate_accum_enable
		&& !eff.clock_source_select;
	// external source relies on software having routed the pin
	assign raw_tick = eff.clock_source_select ? ext_rise
		: (half_reg && (!gated_mode || gate_level));
	assign ps_clear = !eff.on;

	stc_prescaler u_ps (
		.pclk     (pclk),
		.presetn  (presetn),
		.clear    (ps_clear),
		.sel      (eff.input_prescale_select),
		.tick_in  (raw_tick),
		.tick_out (ps_tick)
	);

	assign adv = eff.on && ps_tick;

	always_comb begin
		half_next     = ~half_reg;
		gate_dly_next = gate_level;
		ctrl_next     = ctrl_reg;
		count_next    = count_reg;
		period_next   = period_reg;
		match_next    = 1'b0;
		ovf_next      = ovf_reg;
		if (adv) begin
			if (count_reg == period_reg) begin
				count_next = 16'h0000;
				match_next = 1'b1;
				ovf_next   = 1'b1;
			end else begin
				count_next = count_reg + 16'h0001;
			end
		end
		if (wr) begin
			unique case (req.addr)
				STC_CTRL_OFS:   ctrl_next = req.wdata[15:0] & STC_CTRL_MASK;
				STC_COUNT_OFS:  count_next = req.wdata[15:0];
				STC_PERIOD_OFS: period_next = req.wdata[15:0];
				STC_STATUS_OFS: begin
					if (req.wdata[0] && !(adv && count_reg == period_reg)) begin
						ovf_next = 1'b0;
					end
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		prdata_next = prdata_reg;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				STC_CTRL_OFS:   prdata_next = {16'h0000, ctrl_reg};
				STC_COUNT_OFS:  prdata_next = {16'h0000, count_reg};
				STC_PERIOD_OFS: prdata_next = {16'h0000, period_reg};
				STC_STATUS_OFS: prdata_next = {29'h0000_0000,
					gate_dly_reg, eff.on, ovf_reg};
				default:        prdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= STC_CTRL_RST;
			count_reg    <= STC_COUNT_RST;
			period_reg   <= STC_PERIOD_RST;
			prdata_reg   <= 32'h0000_0000;
			match_reg    <= 1'b0;
			half_reg     <= 1'b0;
			gate_dly_reg <= 1'b0;
			ovf_reg      <= 1'b0;
		end else begin
			ctrl_reg     <= ctrl_next;
			count_reg    <= count_next;
			period_reg   <= period_next;
			prdata_reg   <= prdata_next;
			match_reg    <= match_next;
			half_reg     <= half_next;
			gate_dly_reg <= gate_dly_next;
			ovf_reg      <= ovf_next;
		end
	end

	assign prdata       = prdata_reg;
	assign pready       = 1'b1;
	assign pslverr      = acc && !hit;
	assign count_value  = count_reg;
	assign period_match = match_reg;
endmodule

/* testbench/stc_asserts.sv */
// Purpose: port checks for stc_top
// Assumes: pair mode shows the control word at the ports
// Notes: bound below
`timescale 1ns/1ps
module stc_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        gate_pin,
	input wire logic        pair_32bit,
	input wire logic [15:0] partner_ctrl,
	input wire logic [15:0] count_value
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_cfg(logic [15:0] c, logic g);
		pair_32bit && partner_ctrl == c && gate_pin == g && !psel;
	endsequence
	chk_int_counts: assert property (s_cfg(16'h8000, 1'b0)[*6]
		|-> count_value != $past(count_value, 2)) else $error("no tick");
	chk_div8_spacing: assert property (s_cfg(16'h8010, 1'b0)[*8]
		##0 $changed(count_value) |=> $stable(count_value)[*8])
		else $error("div 8 too fast");
	chk_gate_holds: assert property (s_cfg(16'h8040, 1'b0)[*6]
		|-> $stable(count_value)) else $error("gate low counted");
	chk_gate_passes: assert property (s_cfg(16'h8040, 1'b1)[*8]
		|-> count_value != $past(count_value, 2)) else $error("gate stuck");
	chk_ext_no_gate: assert property (s_cfg(16'h8042, 1'b0)[*8]
		##1 s_cfg(16'h8042, 1'b0)[*8] |-> count_value
		!= $past(count_value, 8)) else $error("ext gated");
	chk_own_ignored: assert property ((pair_32bit && !partner_ctrl[15]
		&& !psel)[*3] |-> $stable(count_value)) else $error("own ctrl used");
endmodule
bind stc_top stc_asserts i_stc_asserts (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.gate_pin(gate_pin),
	.pair_32bit(pair_32bit),
	.partner_ctrl(partner_ctrl),
	.count_value(count_value)
);

/* testbench/stc_pin_model.sv */
// Purpose: far side pin clock source
// Assumes: rising edge every 8 pclk while running
// Notes: pin rests low when stopped
`timescale 1ns/1ps
module stc_pin_model (
	input  wire logic pclk,
	input  wire logic run,
	output logic      pin
);
	logic [1:0] div_reg = 2'h0;
	// runs only once the pin is routed and enabled
	always @(posedge pclk) begin
		div_reg <= run ? div_reg + 2'h1 : 2'h0;
		if (!run)
			pin <= 1'b0;
		else if (div_reg == 2'h3)
			pin <= ~pin;
	end
endmodule

/* testbench/slave_timer_control_tb.sv */
// Purpose: apb tests for stc_top
// Assumes: zero wait apb slave
// Notes: counts may be one above the ideal
`timescale 1ns/1ps
module slave_timer_control_tb
	import stc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        ext_run, ext_pin, gate_pin, pair_32bit, er;
	logic        period_match;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] partner_ctrl, count_value;
	logic [15:0] pc [5] = '{16'h8000, 16'h8010, 16'h8040, 16'h8040, 16'h8042};
	int          fail_count = 0;
	int          n_compared = 0;
	int          dv;
	int          n_match = 0;
	int          m0;
	stc_top i_stc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_count_pin(ext_pin), .gate_pin(gate_pin),
		.pair_32bit(pair_32bit), .partner_ctrl(partner_ctrl),
		.count_value(count_value), .period_match(period_match));
	stc_pin_model i_stc_pin_model (.pclk(pclk), .run(ext_run), .pin(ext_pin));
	// counts wrap pulses so the period test can compare them
	always @(posedge pclk) begin
		if (period_match === 1'b1)
			n_match <= n_match + 1;
	end
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input logic [31:0] got, lo, hi);
		n_compared++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t got %h want %h..%h", $time, got, lo, hi);
		end
	endtask
	// counter on for exactly span cycles, then read back
	task automatic run(input logic [15:0] c, input int span, lo);
		apb(STC_COUNT_OFS, 1'b1, 32'h0000_0000);
		apb(STC_CTRL_OFS, 1'b1, {16'h0000, c});
		repeat (span - 3) @(posedge pclk);
		apb(STC_CTRL_OFS, 1'b1, 32'h0000_0000);
		apb(STC_COUNT_OFS, 1'b0, 32'h0000_0000);
		chk(rd, lo, lo + (lo != 0));
		$display("run %h done", c);
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		stop_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, ext_run, gate_pin, pair_32bit} = '0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		partner_ctrl = 16'h0000;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(STC_CTRL_OFS, 1'b0, 32'h0000_0000);
		chk(rd, 32'(STC_CTRL_RST), 32'(STC_CTRL_RST));
		apb(STC_PERIOD_OFS, 1'b0, 32'h0000_0000);
		chk(rd, 32'(STC_PERIOD_RST), 32'(STC_PERIOD_RST));
		apb(12'h010, 1'b0, 32'h0000_0000);
		chk({rd[30:0], er}, 32'h0000_0001, 32'h0000_0001);
		apb(STC_CTRL_OFS, 1'b1, 32'h0000_FFFF);
		apb(STC_CTRL_OFS, 1'b0, 32'h0000_0000);
		chk(rd, 32'(STC_CTRL_MASK), 32'(STC_CTRL_MASK));
		$display("register test done");
		for (int ps = 0; ps < 4; ps++) begin
			dv = (ps == 3) ? 256 : 1 << (3 * ps);
			run(16'h8000 | 16'(ps << 4), 9 * dv, 4);
		end
		run(16'h8040, 9, 0);
		gate_pin <= 1'b1;
		run(16'h8040, 9, 4);
		gate_pin <= 1'b0;
		ext_run <= 1'b1;
		run(16'h8042, 36, 4);
		// period 3 wraps every 4th tick: 17 or 18 ticks give 4 pulses
		apb(STC_PERIOD_OFS, 1'b1, 32'h0000_0003);
		m0 = n_match;
		run(16'h8000, 35, 1);
		chk(n_match - m0, 32'h0000_0004, 32'h0000_0004);
		apb(STC_STATUS_OFS, 1'b0, 32'h0000_0000);
		chk(rd, 32'h0000_0001, 32'h0000_0001);
		apb(STC_STATUS_OFS, 1'b1, 32'h0000_0001);
		apb(STC_STATUS_OFS, 1'b0, 32'h0000_0000);
		chk(rd, 32'h0000_0000, 32'h0000_0000);
		apb(STC_PERIOD_OFS, 1'b1, 32'h0000_FFFF);
		$display("period test done");
		pair_32bit <= 1'b1;
		run(16'h8000, 9, 0);
		for (int i = 0; i < 5; i++) begin
			partner_ctrl <= pc[i];
			gate_pin <= (i == 3);
			repeat (40) @(posedge pclk);
		end
		partner_ctrl <= 16'h0000;
		pair_32bit <= 1'b0;
		$display("pair test done");
		stop_test();
	end
endmodule
